/* inc/spi_regs_defines.svh */
// constants of the serial register slave: frame layout, command bits, timing
// assumes a single 25 MHz core clock
`ifndef SPI_REGS_DEFINES_SVH
`define SPI_REGS_DEFINES_SVH

`define FRAME_BITS        5'h10
`define ADDR_BITS         7
`define NUM_WORDS         64
`define BACKED_WORDS      27
`define RW_BIT            15
`define ADDR_MSB          14
`define ADDR_LSB          8
`define GLOBAL_CMD_ADDR   7'h3E
`define FLASH_UPDATE_BIT  6
`define SOFT_RESET_BIT    7
`define CLK_PERIOD_NS     40
`define RECOVERY_MS       54
`define RECOVERY_CYCLES   ((`RECOVERY_MS * 1000000) / `CLK_PERIOD_NS)
`define WORD_RESET        16'h0000

`endif

/* inc/spi_regs_pkg.sv */
// types shared by the serial register slave
// assumes spi_regs_defines.svh is on the include path
`default_nettype none
package spi_regs_pkg;

    typedef enum logic [1:0]
    {
        ST_RESTORE = 2'b00,
        ST_RECOVER = 2'b01,
        ST_RUN     = 2'b10
    } life_state_t;

    typedef struct packed
    {
        logic       write;
        logic [6:0] addr;
        logic [7:0] data;
    } frame_t;

    typedef struct packed
    {
        logic sclk;
        logic cs_n;
        logic din;
    } link_in_t;

endpackage
`default_nettype wire

/* rtl/spi_regs.sv */
// serial slave and dual-memory user register store
// assumes mode 3 master, sclk far slower than core_clk; pins are asynchronous
`default_nettype none
`include "spi_regs_defines.svh"

module spi_regs
#(
    parameter int unsigned RECOVERY_CYCLES = `RECOVERY_CYCLES
)
(
    // core
    input  wire logic core_clk,
    input  wire logic rst,
    // pins
    input  wire logic rst_pin_n,
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic din,
    output logic      dout,
    output logic      dout_oe_n,
    // status
    output logic      data_ready,
    output logic      flash_busy
);
    spi_regs_pkg::link_in_t      s1_q;
    spi_regs_pkg::link_in_t      s2_q;
    logic                        sclk_d1_q;
    logic                        rpin1_q;
    logic                        rpin2_q;
    logic [15:0]                 sram_q [`NUM_WORDS];
    logic [15:0]                 flash_q [`NUM_WORDS];
    logic [`NUM_WORDS-1:0]       backed;
    logic [15:0]                 rx_q;
    logic [15:0]                 tx_q;
    logic [4:0]                  cnt_q;
    logic [6:0]                  rd_addr_q;
    spi_regs_pkg::life_state_t   st_q;
    logic [31:0]                 rec_q;
    logic [5:0]                  idx_q;
    logic                        rise;
    logic                        fall;
    logic                        frame_done;
    spi_regs_pkg::frame_t        fr;
    logic                        soft_rst;
    logic                        save;

    // flash-backed words: the low control block
    always_comb
    begin
        for (int i = 0; i < `NUM_WORDS; i++)
        begin
            backed[i] = (i < `BACKED_WORDS);
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_q      <= '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};
            s2_q      <= '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};
            sclk_d1_q <= 1'b1;
            rpin1_q   <= 1'b1;
            rpin2_q   <= 1'b1;
        end
        else
        begin
            s1_q      <= '{sclk: sclk, cs_n: cs_n, din: din};
            s2_q      <= s1_q;
            sclk_d1_q <= s2_q.sclk;
            rpin1_q   <= rst_pin_n;
            rpin2_q   <= rpin1_q;
        end
    end

    assign rise       = !s2_q.cs_n && s2_q.sclk && !sclk_d1_q;
    assign fall       = !s2_q.cs_n && !s2_q.sclk && sclk_d1_q;
    assign frame_done = rise && (cnt_q == `FRAME_BITS - 5'h01);
    assign fr         = {rx_q[14:0], s2_q.din};
    assign soft_rst   = frame_done && fr.write && (st_q == spi_regs_pkg::ST_RUN)
                        && (fr.addr == `GLOBAL_CMD_ADDR) && fr.data[`SOFT_RESET_BIT];
    assign save       = frame_done && fr.write && (st_q == spi_regs_pkg::ST_RUN)
                        && (fr.addr == `GLOBAL_CMD_ADDR) && fr.data[`FLASH_UPDATE_BIT];

    // receive shift register and bit count; a high chip select aborts the frame
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_q  <= `WORD_RESET;
            cnt_q <= 5'h00;
        end
        else if (s2_q.cs_n)
        begin
            cnt_q <= 5'h00;
        end
        else if (rise)
        begin
            rx_q  <= fr;
            cnt_q <= frame_done ? 5'h00 : cnt_q + 5'h01;
        end
    end

    // read address latched at frame end, answered in the next frame
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_addr_q <= 7'h00;
        end
        else if (frame_done && !fr.write)
        begin
            rd_addr_q <= fr.addr;
        end
    end

    // transmit: load at first falling edge of a frame, shift on later ones
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_q <= `WORD_RESET;
            dout <= 1'b0;
        end
        else if (fall)
        begin
            if (cnt_q == 5'h00)
            begin
                tx_q <= {sram_q[rd_addr_q[6:1]][14:0], 1'b0};
                dout <= sram_q[rd_addr_q[6:1]][15];
            end
            else
            begin
                tx_q <= {tx_q[14:0], 1'b0};
                dout <= tx_q[15];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            dout_oe_n <= 1'b1;
        end
        else
        begin
            dout_oe_n <= s2_q.cs_n;
        end
    end

    // life cycle: restore, recovery wait, run
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q  <= spi_regs_pkg::ST_RESTORE;
            idx_q <= 6'h00;
            rec_q <= 32'h0;
        end
        else if (!rpin2_q || soft_rst)
        begin
            st_q  <= spi_regs_pkg::ST_RESTORE;
            idx_q <= 6'h00;
            rec_q <= 32'h0;
        end
        else
        begin
            case (st_q)
                spi_regs_pkg::ST_RESTORE:
                begin
                    idx_q <= idx_q + 6'h01;
                    if (idx_q == 6'(`NUM_WORDS - 1))
                    begin
                        st_q <= spi_regs_pkg::ST_RECOVER;
                    end
                end
                spi_regs_pkg::ST_RECOVER:
                begin
                    rec_q <= rec_q + 32'h1;
                    if (rec_q >= RECOVERY_CYCLES - 1)
                    begin
                        st_q <= spi_regs_pkg::ST_RUN;
                    end
                end
                spi_regs_pkg::ST_RUN:
                begin
                    st_q <= spi_regs_pkg::ST_RUN;
                end
                default:
                begin
                    st_q <= spi_regs_pkg::ST_RESTORE;
                end
            endcase
        end
    end

    // working copy: restored word by word, written a byte per frame
    always_ff @(posedge core_clk)
    begin
        if (st_q == spi_regs_pkg::ST_RESTORE)
        begin
            sram_q[idx_q] <= flash_q[idx_q];
        end
        else if (frame_done && fr.write && (st_q == spi_regs_pkg::ST_RUN))
        begin
            if (fr.addr[0])
            begin
                sram_q[fr.addr[6:1]][15:8] <= fr.data;
            end
            else
            begin
                sram_q[fr.addr[6:1]][7:0] <= fr.data;
            end
        end
    end

    // nonvolatile copy: only changed by the update command, no reset on purpose
    always_ff @(posedge core_clk)
    begin
        if (save)
        begin
            for (int i = 0; i < `NUM_WORDS; i++)
            begin
                if (backed[i])
                begin
                    flash_q[i] <= sram_q[i];
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            data_ready <= 1'b0;
            flash_busy <= 1'b0;
        end
        else
        begin
            data_ready <= (st_q == spi_regs_pkg::ST_RUN);
            flash_busy <= save;
        end
    end

endmodule
`default_nettype wire

/* sim/spi_regs_props.sv */
// checker of the serial register slave, sees only its ports
// assumes sclk half periods of at least 4 core cycles
`default_nettype none
module spi_regs_props
#(
    parameter int unsigned RECOVERY_CYCLES = 20
)
(
    // clock and resets
    input wire logic core_clk,
    input wire logic rst,
    input wire logic rst_pin_n,
    // link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe_n,
    // status
    input wire logic data_ready,
    input wire logic flash_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned since_q;
    logic        ready_d1_q;
    // restarts on pin reset and when data_ready drops, so a command reset is timed too
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            since_q    <= 0;
            ready_d1_q <= 1'b0;
        end
        else
        begin
            ready_d1_q <= data_ready;
            if (!rst_pin_n || (ready_d1_q && !data_ready))
                since_q <= 0;
            else
                since_q <= since_q + 1;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    a_oe_release: assert property (cs_n [*5] |-> dout_oe_n)
        else $error("dout driven while deselected");
    a_oe_drive: assert property ($fell(cs_n) |-> ##[1:4] !dout_oe_n)
        else $error("dout not driven after select");
    a_dout_hold: assert property ($rose(sclk) && !cs_n |-> ##2 $stable(dout) [*2])
        else $error("dout moved while sclk high");
    a_ready_time: assert property ($rose(data_ready) |->
        since_q >= 63 + RECOVERY_CYCLES && since_q <= 72 + RECOVERY_CYCLES)
        else $error("data ready at wrong time");
    a_ready_drop: assert property (!rst_pin_n |-> ##[1:4] !data_ready)
        else $error("data ready kept during pin reset");
    a_busy_pulse: assert property (flash_busy |=> !flash_busy)
        else $error("save pulse too long");
    a_busy_quiet: assert property (cs_n [*8] |-> !flash_busy)
        else $error("save without command");
    a_busy_run: assert property (flash_busy |-> data_ready)
        else $error("save outside run");
endmodule

bind spi_regs spi_regs_props #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) spi_regs_props_i
(
    .core_clk(core_clk), .rst(rst), .rst_pin_n(rst_pin_n), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .dout_oe_n(dout_oe_n), .data_ready(data_ready),
    .flash_busy(flash_busy)
);
`default_nettype wire

/* sim/spi_master_model.sv */
// serial master stand-in: mode 3, msb first, 16-bit frames
// assumes a 40 ns core clock; sclk half period is 4 core cycles
`default_nettype none
module spi_master_model
(
    input  wire logic core_clk,
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b1;
    end
    task automatic half();
        repeat (4) @(negedge core_clk);
    endtask
    // entered at a falling core edge; frames may follow back to back
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        cs_n = 1'b0;
        half();
        for (int i = 15; i >= 0; i--)
        begin
            sclk = 1'b0;
            din  = tx[i];
            half();
            sclk = 1'b1;
            rx[i] = dout;
            half();
        end
        cs_n = 1'b1;
        // released line shows no stale bit
        din = ~din;
        half();
    endtask
endmodule
`default_nettype wire

/* sim/test_spi_regs.sv */
// self-checking bench of the serial register slave
// assumes the master model and the bound checker are compiled first
`default_nettype none
module test_spi_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned REC = 20;
    logic        core_clk, rst, rst_pin_n, sclk, cs_n, din;
    logic        dout, dout_oe_n, data_ready, flash_busy;
    logic [15:0] rx;
    int          err_total, checked, busy_seen;
    spi_regs #(.RECOVERY_CYCLES(REC)) spi_regs_i
    (
        .core_clk(core_clk), .rst(rst), .rst_pin_n(rst_pin_n), .sclk(sclk),
        .cs_n(cs_n), .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
        .data_ready(data_ready), .flash_busy(flash_busy)
    );
    spi_master_model spi_master_model_i
    (
        .core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout)
    );
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // counted where the pulse has settled; scenarios compare against a snapshot
    always @(negedge core_clk)
        if (flash_busy === 1'b1)
            busy_seen++;
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (data_ready !== 1'b1 && n < 400)
        begin
            @(negedge core_clk);
            n++;
        end
        check("data_ready", 16'h0001, {15'h0, data_ready});
        if (data_ready !== 1'b1)
            final_report();
    endtask
    task automatic xf(input logic [15:0] w);
        spi_master_model_i.xfer(w, rx);
    endtask
    task automatic t_bytes();
        int b0;
        b0 = busy_seen;
        xf({1'b1, 7'h06, 8'h5A});
        xf({1'b1, 7'h07, 8'hC3});
        xf({1'b0, 7'h06, 8'h00});
        xf({1'b0, 7'h07, 8'h00});
        check("word by low byte", 16'hC35A, rx);
        xf(16'h0000);
        check("word by high byte", 16'hC35A, rx);
        check("stray saves", 16'h0000, 16'(busy_seen - b0));
    endtask
    task automatic t_save();
        int b0;
        b0 = busy_seen;
        xf(16'hBE40);
        xf({1'b0, 7'h06, 8'h00});
        check("save pulses", 16'h0001, 16'(busy_seen - b0));
        xf(16'h0000);
        check("word after save", 16'hC35A, rx);
    endtask
    task automatic t_restore();
        xf({1'b1, 7'h06, 8'h11});
        xf({1'b0, 7'h06, 8'h00});
        xf(16'h0000);
        check("unsaved word", 16'hC311, rx);
        rst_pin_n = 1'b0;
        repeat (6) @(negedge core_clk);
        check("ready in pin reset", 16'h0000, {15'h0, data_ready});
        rst_pin_n = 1'b1;
        wait_ready();
        xf({1'b0, 7'h07, 8'h00});
        xf(16'h0000);
        check("restored word", 16'hC35A, rx);
    endtask
    task automatic t_soft();
        xf({1'b1, 7'h06, 8'h77});
        xf(16'hBE80);
        check("ready after command reset", 16'h0000, {15'h0, data_ready});
        wait_ready();
        xf({1'b0, 7'h06, 8'h00});
        xf(16'h0000);
        check("word after command reset", 16'hC35A, rx);
    endtask
    initial
    begin
        rst = 1'b1;
        rst_pin_n = 1'b1;
        err_total = 0;
        checked = 0;
        repeat (8) @(negedge core_clk);
        check("oe in reset", 16'h0001, {15'h0, dout_oe_n});
        rst = 1'b0;
        wait_ready();
        t_bytes();
        t_save();
        t_restore();
        t_soft();
        final_report();
    end
endmodule
`default_nettype wire
